// ===== rtl/branch_compare_skip_exec_defs.vh
// constants for the control-flow and compare execution unit
`ifndef BRANCH_COMPARE_SKIP_EXEC_DEFS_VH
`define BRANCH_COMPARE_SKIP_EXEC_DEFS_VH
// operation select codes
`define OP_NONE             4'h0
`define OP_INDIRECT_CALL    4'h1
`define OP_CMP_SKIP_EQUAL   4'h2
`define OP_CMP_REGISTERS    4'h3
`define OP_CMP_WITH_BORROW  4'h4
`define OP_CMP_IMMEDIATE    4'h5
`define OP_SKIP_GPR_CLEAR   4'h6
`define OP_SKIP_GPR_ONE     4'h7
`define OP_SKIP_IO_CLEAR    4'h8
`define OP_SKIP_IO_ONE      4'h9
`define OP_BRANCH_FLAG_ONE  4'hA
`define OP_BRANCH_FLAG_ZERO 4'hB
`define OP_BRANCH_NO_CARRY  4'hC
`define OP_BRANCH_UNS_GE    4'hD
// status flag positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
// cycle counts
`define CYC_ONE       2'h1
`define CYC_TWO       2'h2
`define CYC_THREE     2'h3
`define CALL_CYCLES   2'h3
// program counter steps
`define PC_STEP_ONE   16'h0001
`define PC_STEP_TWO   16'h0002
`define PC_STEP_THREE 16'h0003
`define PC_RESET      16'h0000
`define STATUS_FLAGS_REGISTER_RESET    8'h00
`endif

// ===== rtl/branch_compare_skip_exec.v
// execution unit for call, compare, skip and flag-branch operations
`timescale 1ns/10ps
`include "branch_compare_skip_exec_defs.vh"
module branch_compare_skip_exec
(
    input  wire        clock_in,         // core clock, 100 MHz
    input  wire        sys_rst_in,       // synchronous reset, high
    input  wire        issue_in,         // one-cycle start of an operation
    input  wire [3:0]  op_in,            // operation select code
    input  wire [7:0]  dest_operand_in,  // destination register value
    input  wire [7:0]  source_operand_in,// source register value
    input  wire [7:0]  immediate_in,     // constant for immediate compare
    input  wire [7:0]  io_value_in,      // addressed I/O register value
    input  wire [2:0]  bit_select_in,    // bit or flag index
    input  wire [6:0]  offset_in,        // signed relative offset
    input  wire [15:0] pointer_in,       // indirect pointer pair
    input  wire        next_two_word_in, // following instruction is 2 words
    output wire        busy_out,         // operation still running
    output reg         done_out,         // pulse on final cycle
    output reg  [15:0] pc_out,           // program counter
    output reg  [7:0]  status_out,       // status flags register
    output reg         push_out,         // pulse: save return address
    output reg  [15:0] return_addr_out   // return address to save
);

    localparam ST_IDLE = 1'b0;           // ready for an operation
    localparam ST_WAIT = 1'b1;           // burning extra cycles

    reg        state_reg;                // controller state
    reg        state_next;
    reg [1:0]  remain_reg;               // extra cycles left
    reg [1:0]  remain_next;
    reg [15:0] pc_next;
    reg [15:0] target_reg;               // pc committed at final cycle
    reg [15:0] target_next;
    reg [7:0]  status_next;
    reg        done_next;
    reg        push_next;
    reg [15:0] ret_next;
    reg [7:0]  sub_op;                   // subtrahend of a compare
    reg        sub_borrow;               // carry term of a compare
    reg        do_cmp;                   // compare updates flags
    reg        skip_cond;                // skip condition holds
    reg        br_cond;                  // branch condition holds
    reg        is_skip;                  // operation is a skip kind
    reg        is_branch;                // operation is a branch kind
    wire [7:0] diff;                     // compare result, discarded
    wire [8:0] wide;                     // subtraction with borrow out
    wire [15:0] pc_plus1;                // address of next word
    wire [15:0] branch_target;           // pc + k + 1
    wire [15:0] skip_len;                // step used when skipping

    // bit pick used by the register and I/O skip tests and the flag branches
    function sel_bit;
        input [7:0] value;
        input [2:0] index;
        begin
            sel_bit = value[index];
        end
    endfunction

    assign busy_out = (state_reg == ST_WAIT);
    assign wide = {1'b0, dest_operand_in} - {1'b0, sub_op}
                  - {8'h00, sub_borrow};
    assign diff = wide[7:0];
    assign pc_plus1 = pc_out + `PC_STEP_ONE;
    // offset sign-extended; wraps modulo the address space
    assign branch_target = pc_plus1 + {{9{offset_in[6]}}, offset_in};
    // the skipped instruction's length sets the step
    assign skip_len = next_two_word_in ? `PC_STEP_THREE : `PC_STEP_TWO;

    // operand selection and condition decode
    always @*
    begin
        sub_op     = source_operand_in;
        sub_borrow = 1'b0;
        do_cmp     = 1'b0;
        skip_cond  = 1'b0;
        br_cond    = 1'b0;
        is_skip    = 1'b0;
        is_branch  = 1'b0;
        case (op_in)
            `OP_CMP_REGISTERS:           // plain register compare
            begin
                do_cmp = 1'b1;
            end
            `OP_CMP_WITH_BORROW:         // also subtracts carry
            begin
                do_cmp     = 1'b1;
                sub_borrow = status_out[`FLAG_C];
            end
            `OP_CMP_IMMEDIATE:           // constant operand
            begin
                do_cmp = 1'b1;
                sub_op = immediate_in;
            end
            `OP_CMP_SKIP_EQUAL:          // equality skip, no flags
            begin
                is_skip   = 1'b1;
                skip_cond = (dest_operand_in == source_operand_in);
            end
            `OP_SKIP_GPR_CLEAR:
            begin
                is_skip   = 1'b1;
                skip_cond = ~sel_bit(source_operand_in, bit_select_in);
            end
            `OP_SKIP_GPR_ONE:
            begin
                is_skip   = 1'b1;
                skip_cond = sel_bit(source_operand_in, bit_select_in);
            end
            `OP_SKIP_IO_CLEAR:
            begin
                is_skip   = 1'b1;
                skip_cond = ~sel_bit(io_value_in, bit_select_in);
            end
            `OP_SKIP_IO_ONE:
            begin
                is_skip   = 1'b1;
                skip_cond = sel_bit(io_value_in, bit_select_in);
            end
            `OP_BRANCH_FLAG_ONE:
            begin
                is_branch = 1'b1;
                br_cond   = sel_bit(status_out, bit_select_in);
            end
            `OP_BRANCH_FLAG_ZERO:
            begin
                is_branch = 1'b1;
                br_cond   = ~sel_bit(status_out, bit_select_in);
            end
            `OP_BRANCH_NO_CARRY:
            begin
                is_branch = 1'b1;
                br_cond   = ~status_out[`FLAG_C];
            end
            `OP_BRANCH_UNS_GE:           // alias of the carry-clear case
            begin
                is_branch = 1'b1;
                br_cond   = ~status_out[`FLAG_C];
            end
            default:
            begin
                is_skip = 1'b0;          // call or no-op: nothing here
            end
        endcase
    end

    // controller: decides next pc, flags and the cycle count
    always @*
    begin
        state_next  = state_reg;
        remain_next = remain_reg;
        pc_next     = pc_out;
        target_next = target_reg;
        status_next = status_out;
        done_next   = 1'b0;
        push_next   = 1'b0;
        ret_next    = return_addr_out;
        case (state_reg)
            ST_IDLE:
            begin
                if (issue_in)
                begin
                    if (op_in == `OP_INDIRECT_CALL)
                    begin
                        // save pc+1, jump after the full 3 cycles
                        push_next   = 1'b1;
                        ret_next    = pc_plus1;
                        target_next = pointer_in;
                        remain_next = `CALL_CYCLES - `CYC_ONE;
                        state_next  = ST_WAIT;
                    end
                    else if (is_skip && skip_cond)
                    begin
                        // one extra cycle per skipped word
                        target_next = pc_out + skip_len;
                        remain_next = next_two_word_in ?
                            (`CYC_THREE - `CYC_ONE) :
                            (`CYC_TWO - `CYC_ONE);
                        state_next  = ST_WAIT;
                    end
                    else if (is_branch && br_cond)
                    begin
                        // taken branch costs a second cycle
                        target_next = branch_target;
                        remain_next = `CYC_TWO - `CYC_ONE;
                        state_next  = ST_WAIT;
                    end
                    else
                    begin
                        // single-cycle: not taken, compare or no-op
                        pc_next   = pc_plus1;
                        done_next = 1'b1;
                        if (do_cmp)
                        begin
                            // result discarded, only flags change
                            status_next[`FLAG_Z] = (diff == 8'h00) &
                                ((op_in != `OP_CMP_WITH_BORROW) |
                                 status_out[`FLAG_Z]);
                            status_next[`FLAG_N] = diff[7];
                            status_next[`FLAG_V] =
                                (dest_operand_in[7] & ~sub_op[7] &
                                 ~diff[7]) |
                                (~dest_operand_in[7] & sub_op[7] &
                                 diff[7]);
                            status_next[`FLAG_C] = wide[8];
                            status_next[`FLAG_H] =
                                (~dest_operand_in[3] & sub_op[3]) |
                                (sub_op[3] & diff[3]) |
                                (diff[3] & ~dest_operand_in[3]);
                            status_next[`FLAG_S] = diff[7] ^
                                status_next[`FLAG_V];
                        end
                    end
                end
            end
            ST_WAIT:
            begin
                // no new operation is taken while busy
                remain_next = remain_reg - `CYC_ONE;
                if (remain_reg == `CYC_ONE)
                begin
                    pc_next    = target_reg;
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state and output registers
    always @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            state_reg       <= ST_IDLE;
            remain_reg      <= 2'h0;
            target_reg      <= `PC_RESET;
            pc_out          <= `PC_RESET;
            status_out      <= `STATUS_FLAGS_REGISTER_RESET;
            done_out        <= 1'b0;
            push_out        <= 1'b0;
            return_addr_out <= `PC_RESET;
        end
        else
        begin
            state_reg       <= state_next;
            remain_reg      <= remain_next;
            target_reg      <= target_next;
            pc_out          <= pc_next;
            status_out      <= status_next;
            done_out        <= done_next;
            push_out        <= push_next;
            return_addr_out <= ret_next;
        end
    end

endmodule // branch_compare_skip_exec

// ===== test/branch_compare_skip_exec_chk.sv
// assertion checker for the call, compare, skip and branch unit
`timescale 1ns/10ps
`include "branch_compare_skip_exec_defs.vh"
module branch_compare_skip_exec_chk
(
    input wire        clock_in,
    input wire        sys_rst_in,
    input wire        issue_in,
    input wire [3:0]  op_in,
    input wire [7:0]  dest_operand_in,
    input wire [7:0]  source_operand_in,
    input wire [7:0]  immediate_in,
    input wire [7:0]  io_value_in,
    input wire [2:0]  bit_select_in,
    input wire [6:0]  offset_in,
    input wire [15:0] pointer_in,
    input wire        next_two_word_in,
    input wire        busy_out,
    input wire        done_out,
    input wire [15:0] pc_out,
    input wire [7:0]  status_out,
    input wire        push_out,
    input wire [15:0] return_addr_out
);
    wire        go;    // request accepted: refused ones never count
    wire [15:0] k_ext; // sign-extended relative offset
    wire [2:0]  b;     // bit or flag index
    assign go = issue_in && !busy_out;
    assign k_ext = {{9{offset_in[6]}}, offset_in};
    assign b = bit_select_in;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // one extra cycle, then completion
    sequence s_wait_one;
        busy_out && !done_out ##1 done_out;
    endsequence
    // two extra cycles, then completion
    sequence s_wait_two;
        busy_out && !done_out ##1 s_wait_one;
    endsequence
    a_call_save_addr: assert property (go && op_in == `OP_INDIRECT_CALL |=>
        push_out && return_addr_out == $past(pc_out) + 16'h0001 ##0 s_wait_two)
        else $error("call return address or timing wrong");
    a_call_target_pc: assert property (go && op_in == `OP_INDIRECT_CALL |->
        ##3 pc_out == $past(pointer_in, 3) && status_out == $past(status_out, 3))
        else $error("call target or flags wrong");
    a_cmp_zero_flag: assert property (go && op_in == `OP_CMP_REGISTERS |=>
        done_out && status_out[1] == ($past(dest_operand_in) ==
        $past(source_operand_in)) && pc_out == $past(pc_out) + 16'h0001)
        else $error("compare zero flag wrong");
    a_cmpi_carry_flag: assert property (go && op_in == `OP_CMP_IMMEDIATE |=>
        status_out[0] == ($past(dest_operand_in) < $past(immediate_in)))
        else $error("immediate compare carry wrong");
    a_equal_skip_short: assert property (go && op_in == `OP_CMP_SKIP_EQUAL
        && dest_operand_in == source_operand_in && !next_two_word_in |=>
        s_wait_one ##0 pc_out == $past(pc_out, 2) + 16'h0002)
        else $error("equal skip wrong");
    a_gpr_skip_long: assert property (go && op_in == `OP_SKIP_GPR_CLEAR
        && !source_operand_in[b] && next_two_word_in |=>
        s_wait_two ##0 pc_out == $past(pc_out, 3) + 16'h0003)
        else $error("long register bit skip wrong");
    a_gpr_one_flags: assert property (go && op_in == `OP_SKIP_GPR_ONE
        && source_operand_in[b] && !next_two_word_in |=>
        s_wait_one ##0 status_out == $past(status_out, 2))
        else $error("register bit skip changed flags");
    a_io_no_skip: assert property (go && ((op_in == `OP_SKIP_IO_CLEAR
        && io_value_in[b]) || (op_in == `OP_SKIP_IO_ONE && !io_value_in[b]))
        |=> done_out && pc_out == $past(pc_out) + 16'h0001)
        else $error("io skip taken wrongly");
    a_flag_branch_go: assert property (go && ((op_in == `OP_BRANCH_FLAG_ONE
        && status_out[b]) || (op_in == `OP_BRANCH_FLAG_ZERO && !status_out[b]))
        |=> s_wait_one ##0
        pc_out == $past(pc_out, 2) + $past(k_ext, 2) + 16'h0001)
        else $error("flag branch target wrong");
    a_carry_branch_go: assert property (go && (op_in == `OP_BRANCH_NO_CARRY
        || op_in == `OP_BRANCH_UNS_GE) && !status_out[0] |=> s_wait_one ##0
        pc_out == $past(pc_out, 2) + $past(k_ext, 2) + 16'h0001)
        else $error("carry branch target wrong");
endmodule // branch_compare_skip_exec_chk

// ===== test/testbench.sv
// self-checking bench for the call, compare, skip and branch unit
`timescale 1ns/10ps
`include "branch_compare_skip_exec_defs.vh"
module testbench;
    reg          clock_in, sys_rst_in, issue_in, next_two_word_in;
    reg  [3:0]   op_in;
    reg  [7:0]   dest_operand_in, source_operand_in, immediate_in;
    reg  [7:0]   io_value_in;
    reg  [2:0]   bit_select_in;
    reg  [6:0]   offset_in;
    reg  [15:0]  pointer_in;
    wire         busy_out, done_out, push_out;
    wire [15:0]  pc_out, return_addr_out;
    wire [7:0]   status_out;
    logic [15:0] pc_m;  // model program counter
    logic [7:0]  sr_m;  // model flags, bits 6 and 7 stay zero
    int          n_errors = 0;
    int          checks_done = 0;
    branch_compare_skip_exec u_dut
    (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .issue_in(issue_in),
        .op_in(op_in), .dest_operand_in(dest_operand_in),
        .source_operand_in(source_operand_in), .immediate_in(immediate_in),
        .io_value_in(io_value_in), .bit_select_in(bit_select_in),
        .offset_in(offset_in), .pointer_in(pointer_in),
        .next_two_word_in(next_two_word_in), .busy_out(busy_out),
        .done_out(done_out), .pc_out(pc_out), .status_out(status_out),
        .push_out(push_out), .return_addr_out(return_addr_out)
    );
    // free-running core clock, 10 ns period
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // compare one value and count it
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // single exit point of the run
    task print_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // issue one operation; hold keeps issue up one cycle to be refused
    task run_op(input logic [3:0] op, input bit hold);
        logic [8:0]  r;   // difference with borrow in bit 8
        logic [7:0]  s;   // subtrahend
        logic [7:0]  d;   // destination value
        logic [15:0] pc0; // pc before the operation
        logic        hit; // skip or branch condition
        int          lat, want;
        d = 8'($urandom);
        @(posedge clock_in);
        issue_in <= 1'b1;
        op_in <= op;
        dest_operand_in <= d;
        // equal operands half the time so equal-skip fires
        source_operand_in <= $urandom_range(1) ? d : 8'($urandom);
        immediate_in <= 8'($urandom);
        io_value_in <= 8'($urandom);
        bit_select_in <= 3'($urandom);
        offset_in <= 7'($urandom);
        pointer_in <= 16'($urandom);
        next_two_word_in <= 1'($urandom);
        @(posedge clock_in);
        pc0 = pc_m;
        want = 1;
        s = (op == `OP_CMP_IMMEDIATE) ? immediate_in : source_operand_in;
        r = {1'b0, d} - {1'b0, s} - (op == `OP_CMP_WITH_BORROW && sr_m[0]);
        case (op)
            `OP_CMP_SKIP_EQUAL: hit = (d == s);
            `OP_SKIP_GPR_CLEAR: hit = !source_operand_in[bit_select_in];
            `OP_SKIP_GPR_ONE: hit = source_operand_in[bit_select_in];
            `OP_SKIP_IO_CLEAR: hit = !io_value_in[bit_select_in];
            `OP_SKIP_IO_ONE: hit = io_value_in[bit_select_in];
            `OP_BRANCH_FLAG_ONE: hit = sr_m[bit_select_in];
            `OP_BRANCH_FLAG_ZERO: hit = !sr_m[bit_select_in];
            `OP_BRANCH_NO_CARRY, `OP_BRANCH_UNS_GE: hit = !sr_m[0];
            default: hit = 1'b0;
        endcase
        if (op >= `OP_CMP_REGISTERS && op <= `OP_CMP_IMMEDIATE)
        begin
            sr_m[5] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
            sr_m[3] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
            sr_m[2] = r[7];
            sr_m[4] = r[7] ^ sr_m[3];
            // borrow form keeps zero only through a zero result
            sr_m[1] = (r[7:0] == 8'h00) && (op != `OP_CMP_WITH_BORROW || sr_m[1]);
            sr_m[0] = r[8];
        end
        if (op == `OP_INDIRECT_CALL)
        begin
            pc_m = pointer_in;
            want = 3;
        end
        else if (hit && op >= `OP_BRANCH_FLAG_ONE)
        begin
            pc_m = pc_m + {{9{offset_in[6]}}, offset_in} + 16'h0001;
            want = 2;
        end
        else if (hit)
        begin
            want = 2 + next_two_word_in;
            pc_m = pc_m + 16'(want);
        end
        else
            pc_m = pc_m + 16'h0001;
        // an idle unit would take a held issue, so hold only while busy
        issue_in <= hold && want > 1;
        if (hold && want > 1)
            op_in <= `OP_CMP_REGISTERS;
        // a single-cycle op's done stands in the cycle right after the taking edge
        #1;
        lat = 1;
        // bounded wait for completion
        while (done_out !== 1'b1 && lat < 6)
        begin
            @(posedge clock_in);
            issue_in <= 1'b0;
            #1;
            lat++;
        end
        if (done_out !== 1'b1)
        begin
            n_errors++;
            $display("ERROR %0t no completion", $time);
            print_verdict;
        end
        check(16'(lat), 16'(want));
        check(pc_out, pc_m);
        check({8'h00, status_out}, {8'h00, sr_m});
        if (op == `OP_INDIRECT_CALL)
            check(return_addr_out, pc0 + 16'h0001);
    endtask
    // reset, codes 1 to 13 once, random traffic, reset again
    initial
    begin
        void'($urandom(16861));
        {sys_rst_in, issue_in, next_two_word_in} = 3'h4;
        {op_in, dest_operand_in, source_operand_in, immediate_in} = 28'h0;
        {io_value_in, bit_select_in, offset_in, pointer_in} = 34'h0;
        pc_m = 16'h0000;
        sr_m = 8'h00;
        repeat (5) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        for (int i = 1; i < 14; i++)
            run_op(4'(i), i == 1);
        repeat (400) run_op(4'($urandom_range(13, 1)), $urandom_range(1));
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        #1;
        pc_m = 16'h0000;
        sr_m = 8'h00;
        check(pc_out, pc_m);
        check({8'h00, status_out}, {8'h00, sr_m});
        repeat (100) run_op(4'($urandom_range(13, 1)), 0);
        print_verdict;
    end
endmodule // testbench
bind branch_compare_skip_exec branch_compare_skip_exec_chk u_chk
(
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .issue_in(issue_in),
    .op_in(op_in), .dest_operand_in(dest_operand_in),
    .source_operand_in(source_operand_in), .immediate_in(immediate_in),
    .io_value_in(io_value_in), .bit_select_in(bit_select_in),
    .offset_in(offset_in), .pointer_in(pointer_in),
    .next_two_word_in(next_two_word_in), .busy_out(busy_out),
    .done_out(done_out), .pc_out(pc_out), .status_out(status_out),
    .push_out(push_out), .return_addr_out(return_addr_out)
);
